/* core/vhf_pkg.sv */
// package for the valve head feedback logic: register map, field positions,
// timing counts and carrier structs. assumes a 10 MHz aclk.
package vhf_pkg;
    // clock rate and timing
    localparam int CLK_HZ = 10000000;
    localparam int HANDSHAKE_MS = 2000;
    localparam int HANDSHAKE_CYC = HANDSHAKE_MS * (CLK_HZ / 1000);
    localparam int CMD_MIN_MS = 500;
    localparam int CMD_MIN_CYC = CMD_MIN_MS * (CLK_HZ / 1000);
    localparam int MARGIN_MS = 200;
    localparam int MARGIN_CYC = MARGIN_MS * (CLK_HZ / 1000);

    // register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_SETUP = 8'h04;
    localparam logic [7:0] OFF_ERROR = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0c;
    localparam logic [7:0] OFF_IRQ = 8'h10;
    localparam logic [7:0] OFF_MASK = 8'h14;
    localparam logic [7:0] OFF_STROKE = 8'h18;

    // ctrl fields
    localparam int CTRL_BURST = 0;
    localparam int CTRL_US = 1;
    localparam int CTRL_FACTORY = 2;
    localparam int CTRL_SELECT = 3;
    localparam int CTRL_ENTER = 4;
    // setup fields
    localparam int SETUP_VARIANT3 = 0;
    localparam int SETUP_NSOL_LO = 1;
    localparam int SETUP_OK = 3;
    localparam int SETUP_NOSENSOR = 4;
    localparam int SETUP_IFACE_LO = 5;
    // irq bits
    localparam int IRQ_DONE = 0;
    localparam int IRQ_FAULT = 1;

    // reset value, menu positions and led patterns
    localparam logic [31:0] RST_STROKE = 32'h0000_0000;
    localparam logic [4:0] MENU_BURST = 5'h04;
    localparam logic [4:0] MENU_US = 5'h05;
    localparam logic [7:0] LED_BURST = 8'h08;
    localparam logic [7:0] LED_US = 8'h80;

    typedef enum logic [1:0] {IFACE_DISCRETE, IFACE_ASI, IFACE_IOLINK, IFACE_SPARE} vhf_iface_t;

    // solenoid command trio
    typedef struct packed {
        logic lsp;
        logic usl;
        logic main;
    } vhf_sol_t;

    // feedback bits towards the plc
    typedef struct packed {
        logic valve_state;
        logic lsp_bit;
        logic usl_bit;
        logic main_open;
        logic all_closed_feedback;
    } vhf_fb_t;
endpackage

/* core/vhf_top.sv */
// valve head feedback logic: burst seat clean sequencing, fail-safe valve state,
// default and u.s. feedback mapping, axi4-lite register slave.
// assumes plc inputs and sensor flags synchronous to aclk.
//
// Overview of operation
// - burst enable only on three-solenoid unit with 2-3 solenoids after good setup
// - four selects light led 4, enter toggles burst; register also sets it
// - burst off at reset; factory restore forces burst off
// - in burst, rising seat command energises its solenoid
// - in burst, solenoid drops once target position reached, whatever command
// - after a completed pulse, feedback and led hold at least 2 s
// - without seat lift sensor, pulse ends after stored stroke time plus margin
// - discrete/io-link: valve state drops for 16,19-27,29-31; others no effect
// - as-interface: drops only for 16,19-22,31
// - single-solenoid mapping: idle 1/0/1, solenoid one 0/1/1
// - three-solenoid default mapping is one-hot, valve state 1
// - same default mapping on discrete, as-interface and io-link
// - u.s. option only three-solenoid, discrete or as-i, any time vs setup
// - u.s. option gives separate closed bits for upper and lower seat
// - five selects light led 8, enter toggles u.s.; register also sets it
// - u.s. off at reset; stays on through factory restore
// - u.s. map: idle 1011, sv1 0100, sv2 0001, sv3 0010, state 1
//
// Decided for this implementation: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module vhf_top #(
    parameter int HANDSHAKE_CYCLES = vhf_pkg::HANDSHAKE_CYC,
    parameter int MARGIN_CYCLES = vhf_pkg::MARGIN_CYC
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address and data
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // plc commands and valve sensing
    input wire vhf_pkg::vhf_sol_t plc_cmd,
    input wire logic target_reached,
    input wire logic select_button,
    input wire logic enter_button,
    // outputs to valve and plc
    output vhf_pkg::vhf_sol_t solenoid,
    output vhf_pkg::vhf_fb_t feedback,
    output logic [7:0] led,
    output logic irq
);
    // software state
    logic [31:0] ctrl_sw;
    logic [31:0] setup_cfg;
    logic [4:0] error_code;
    logic [31:0] stroke_cyc;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic burst_en;
    logic us_en;
    logic [4:0] menu_pos;
    logic sel_q;
    logic ent_q;
    logic [1:0] cmd_q;
    // burst sequencer
    typedef enum logic [1:0] {ST_IDLE, ST_PULSE, ST_HOLD} vhf_state_t;
    vhf_state_t state;
    logic seat_lsp;
    logic [31:0] timer;
    logic done_evt;
    logic fault_evt;
    // axi
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic do_write;

    // decoded setup information
    logic variant3;
    logic [1:0] nsol;
    logic setup_ok;
    logic no_sensor;
    vhf_pkg::vhf_iface_t iface;
    assign variant3 = setup_cfg[vhf_pkg::SETUP_VARIANT3];
    assign nsol = setup_cfg[vhf_pkg::SETUP_NSOL_LO +: 2];
    assign setup_ok = setup_cfg[vhf_pkg::SETUP_OK];
    assign no_sensor = setup_cfg[vhf_pkg::SETUP_NOSENSOR];
    assign iface = vhf_pkg::vhf_iface_t'(setup_cfg[vhf_pkg::SETUP_IFACE_LO +: 2]);

    logic burst_allowed;
    logic us_allowed;
    assign burst_allowed = variant3 && (nsol >= 2'd2) && setup_ok;
    assign us_allowed = variant3 && (iface == vhf_pkg::IFACE_DISCRETE || iface == vhf_pkg::IFACE_ASI);

    // axi write channel capture, address and data in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (do_write) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (do_write) begin
                w_held <= 1'b0;
            end
        end
    end
    assign do_write = aw_held && w_held && !s_axi_bvalid;

    // ready only while the holding slot is empty
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
            s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
        end
    end

    // write response; unmapped addresses answer slverr
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_addr > vhf_pkg::OFF_STROKE || aw_addr[1:0] != 2'h0) ? 2'h2 : 2'h0;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // byte-lane merge helper
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) r[i*8 +: 8] = nw[i*8 +: 8];
        end
        return r;
    endfunction

    // plain configuration registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            setup_cfg <= 32'h0000_0000;
            error_code <= 5'h00;
            stroke_cyc <= vhf_pkg::RST_STROKE;
            irq_mask <= 2'h0;
            ctrl_sw <= 32'h0000_0000;
        end else begin
            ctrl_sw <= 32'h0000_0000;
            if (do_write) begin
                unique case (aw_addr)
                    vhf_pkg::OFF_CTRL: ctrl_sw <= merge(32'h0000_0000, w_data, w_strb);
                    vhf_pkg::OFF_SETUP: setup_cfg <= merge(setup_cfg, w_data, w_strb);
                    vhf_pkg::OFF_ERROR: error_code <= w_strb[0] ? w_data[4:0] : error_code;
                    vhf_pkg::OFF_MASK: irq_mask <= w_strb[0] ? w_data[1:0] : irq_mask;
                    vhf_pkg::OFF_STROKE: stroke_cyc <= merge(stroke_cyc, w_data, w_strb);
                    default: ;
                endcase
            end
        end
    end

    // ctrl write strobes, one cycle after the write lands
    logic wr_mode;
    logic factory;
    logic sel_edge;
    logic ent_edge;
    assign wr_mode = ctrl_sw[31];
    assign factory = ctrl_sw[vhf_pkg::CTRL_FACTORY];
    assign sel_edge = select_button && !sel_q;
    assign ent_edge = enter_button && !ent_q;

    // button menu: select steps position, enter toggles the option it points at
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sel_q <= 1'b0;
            ent_q <= 1'b0;
            menu_pos <= 5'h00;
        end else begin
            sel_q <= select_button;
            ent_q <= enter_button;
            if (ent_edge) begin
                menu_pos <= 5'h00;
            end else if (sel_edge) begin
                menu_pos <= (menu_pos == vhf_pkg::MENU_US) ? 5'h00 : menu_pos + 5'h01;
            end
        end
    end

    // option bits; a write of ctrl with bit 31 set loads both options directly
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            burst_en <= 1'b0;
            us_en <= 1'b0;
        end else begin
            if (factory) begin
                burst_en <= 1'b0;
            end else if (wr_mode) begin
                burst_en <= ctrl_sw[vhf_pkg::CTRL_BURST] && burst_allowed;
            end else if (ent_edge && menu_pos == vhf_pkg::MENU_BURST) begin
                burst_en <= !burst_en && burst_allowed;
            end else if (!burst_allowed) begin
                burst_en <= 1'b0;
            end
            // factory restore deliberately leaves the u.s. option alone
            if (wr_mode) begin
                us_en <= ctrl_sw[vhf_pkg::CTRL_US] && us_allowed;
            end else if (ent_edge && menu_pos == vhf_pkg::MENU_US) begin
                us_en <= !us_en && us_allowed;
            end else if (!us_allowed) begin
                us_en <= 1'b0;
            end
        end
    end

    // burst sequencer; plc is expected to hold the command 500 ms, so the
    // edge is taken once and the command level is otherwise ignored
    logic usl_rise;
    logic lsp_rise;
    logic [31:0] pulse_limit;
    assign usl_rise = plc_cmd.usl && !cmd_q[0];
    assign lsp_rise = plc_cmd.lsp && !cmd_q[1];
    assign pulse_limit = stroke_cyc + 32'(MARGIN_CYCLES);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= ST_IDLE;
            cmd_q <= 2'h0;
            seat_lsp <= 1'b0;
            timer <= 32'h0000_0000;
            done_evt <= 1'b0;
        end else begin
            cmd_q <= {plc_cmd.lsp, plc_cmd.usl};
            done_evt <= 1'b0;
            unique case (state)
                ST_IDLE: begin
                    timer <= 32'h0000_0000;
                    if (burst_en && (usl_rise || lsp_rise)) begin
                        state <= ST_PULSE;
                        seat_lsp <= lsp_rise && !usl_rise;
                    end
                end
                ST_PULSE: begin
                    timer <= timer + 32'h0000_0001;
                    if (no_sensor ? (timer + 32'h0000_0001 >= pulse_limit) : target_reached) begin
                        state <= ST_HOLD;
                        timer <= 32'h0000_0000;
                        done_evt <= 1'b1;
                    end
                end
                ST_HOLD: begin
                    timer <= timer + 32'h0000_0001;
                    if (timer >= 32'(HANDSHAKE_CYCLES - 1)) begin
                        state <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // error code decode per interface
    logic drop_state;
    always_comb begin
        drop_state = 1'b0;
        if (iface == vhf_pkg::IFACE_ASI) begin
            drop_state = (error_code == 5'h10) || (error_code >= 5'h13 && error_code <= 5'h16)
                || (error_code == 5'h1f);
        end else begin
            drop_state = (error_code == 5'h10) || (error_code >= 5'h13 && error_code <= 5'h1b)
                || (error_code >= 5'h1d);
        end
    end
    assign fault_evt = drop_state && !feedback.valve_state;

    // solenoid drive: burst pulses override, seat drives forced off on single-solenoid units, otherwise plc level passes through
    vhf_pkg::vhf_sol_t next_sol;
    always_comb begin
        next_sol = plc_cmd;
        if (burst_en) begin
            next_sol.usl = (state == ST_PULSE) && !seat_lsp;
            next_sol.lsp = (state == ST_PULSE) && seat_lsp;
        end
        if (!variant3) begin
            next_sol.usl = 1'b0;
            next_sol.lsp = 1'b0;
        end
    end

    // feedback mapping, independent of interface type
    vhf_pkg::vhf_fb_t next_fb;
    always_comb begin
        next_fb = '0;
        next_fb.valve_state = !drop_state;
        if (!variant3) begin
            next_fb.all_closed_feedback = !next_sol.main;
            next_fb.main_open = next_sol.main;
        end else if (us_en) begin
            // closed bits per seat
            next_fb.all_closed_feedback = !(next_sol.main || next_sol.usl || next_sol.lsp);
            next_fb.main_open = next_sol.main;
            next_fb.usl_bit = !next_sol.main && !next_sol.usl;
            next_fb.lsp_bit = !next_sol.main && !next_sol.lsp;
        end else begin
            next_fb.main_open = next_sol.main;
            next_fb.usl_bit = !next_sol.main && next_sol.usl;
            next_fb.lsp_bit = !next_sol.main && !next_sol.usl && next_sol.lsp;
            next_fb.all_closed_feedback = !(next_sol.main || next_sol.usl || next_sol.lsp);
        end
        if (state == ST_HOLD) begin
            // completion handshake on the seat's own feedback bit
            if (seat_lsp) next_fb.lsp_bit = 1'b1;
            else next_fb.usl_bit = 1'b1;
        end
    end

    // registered outputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            solenoid <= '0;
            feedback <= '0;
            led <= 8'h00;
        end else begin
            solenoid <= next_sol;
            feedback <= next_fb;
            led <= ((state == ST_HOLD) ? vhf_pkg::LED_BURST : 8'h00)
                | ((menu_pos == vhf_pkg::MENU_BURST) ? vhf_pkg::LED_BURST : 8'h00)
                | ((menu_pos == vhf_pkg::MENU_US) ? vhf_pkg::LED_US : 8'h00);
        end
    end

    // sticky interrupt status, set beats write-one-to-clear
    logic [1:0] w1c;
    assign w1c = (do_write && aw_addr == vhf_pkg::OFF_IRQ && w_strb[0]) ? w_data[1:0] : 2'h0;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat <= 2'h0;
            irq <= 1'b0;
        end else begin
            irq_stat <= (irq_stat & ~w1c) | {fault_evt, done_evt};
            irq <= |(irq_stat & irq_mask);
        end
    end

    // read channel, one read at a time
    logic [31:0] rd_val;
    always_comb begin
        rd_val = 32'h0000_0000;
        unique case (s_axi_araddr)
            vhf_pkg::OFF_CTRL: rd_val = {30'h0, us_en, burst_en};
            vhf_pkg::OFF_SETUP: rd_val = setup_cfg;
            vhf_pkg::OFF_ERROR: rd_val = {27'h0, error_code};
            vhf_pkg::OFF_STATUS: rd_val = {14'h0, menu_pos, solenoid, feedback, 3'h0, state};
            vhf_pkg::OFF_IRQ: rd_val = {30'h0, irq_stat};
            vhf_pkg::OFF_MASK: rd_val = {30'h0, irq_mask};
            vhf_pkg::OFF_STROKE: rd_val = stroke_cyc;
            default: rd_val = 32'h0000_0000;
        endcase
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h0;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_val;
                s_axi_rresp <= (s_axi_araddr > vhf_pkg::OFF_STROKE || s_axi_araddr[1:0] != 2'h0) ? 2'h2 : 2'h0;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule

/* bench/vhf_assertions.sv */
// checker on the valve head top ports: bus handshakes and burst handshake.
// assumes bind onto vhf_top, single aclk domain.
`timescale 1ns/100ps
module vhf_assertions #(
    parameter int HANDSHAKE_CYCLES = 50
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // valve side
    input wire vhf_pkg::vhf_sol_t plc_cmd,
    input wire vhf_pkg::vhf_sol_t solenoid,
    input wire vhf_pkg::vhf_fb_t feedback,
    input wire logic [7:0] led
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    logic [31:0] hs_left;

    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence seat_pulse_end;
        ($fell(solenoid.usl) && plc_cmd.usl) || ($fell(solenoid.lsp) && plc_cmd.lsp);
    endsequence

    // cycles of handshake still owed; a counter since the hold is far past any repetition
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hs_left <= '0;
        end else if (($fell(solenoid.usl) && plc_cmd.usl) || ($fell(solenoid.lsp) && plc_cmd.lsp)) begin
            hs_left <= 32'(HANDSHAKE_CYCLES - 1);
        end else if (hs_left != 0) begin
            hs_left <= hs_left - 1;
        end
    end

    reset_quiet_a: assert property ($rose(aresetn) |-> solenoid == 3'h0 && feedback == 5'h00)
        else $error("outputs not cleared by reset");
    write_answer_a: assert property (wr_taken |-> ##2 s_axi_bvalid)
        else $error("write response late");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response late");
    bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response withdrawn");
    rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read response withdrawn or changed");
    busy_ready_a: assert property (!(s_axi_rvalid && s_axi_arready)
        && !(s_axi_bvalid && (s_axi_awready || s_axi_wready)))
        else $error("new request accepted while busy");
    pulse_handshake_a: assert property (seat_pulse_end |-> led[3] && (feedback.usl_bit || feedback.lsp_bit))
        else $error("no handshake at pulse end");
    handshake_hold_a: assert property (hs_left != 0 |-> led[3])
        else $error("handshake released early");
endmodule

bind vhf_top vhf_assertions #(.HANDSHAKE_CYCLES(HANDSHAKE_CYCLES)) chk (.aclk, .aresetn, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .plc_cmd, .solenoid, .feedback, .led);

/* bench/vhf_valve_model.sv */
// model of the valve stem and its position sensing behind the solenoids.
// assumes solenoid outputs sampled on aclk; sensor can be removed.
`timescale 1ns/100ps
module vhf_valve_model #(
    parameter int TRAVEL = 8
) (
    // clock
    input wire logic aclk,
    // valve side
    input wire vhf_pkg::vhf_sol_t solenoid,
    input wire logic sensor_on,
    output logic target_reached
);
    int moved = 0;

    // stem moves only while seat air is on, springs back at once when released
    always_ff @(posedge aclk) begin
        if (!(solenoid.usl || solenoid.lsp)) begin
            moved <= 0;
        end else if (moved < TRAVEL) begin
            moved <= moved + 1;
        end
    end
    assign target_reached = sensor_on && (moved == TRAVEL);
endmodule

/* bench/vhf_top_bench.sv */
// self-checking bench for vhf_top: register tasks, mapping, errors, burst.
// assumes the valve model beside the design and a shortened handshake.
`timescale 1ns/100ps
module vhf_top_bench;
    localparam int HS = 50;
    localparam int MG = 10;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [7:0] awaddr, araddr, led;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic tgt, sel, ent, irq, sens;
    vhf_pkg::vhf_sol_t plc_cmd, solenoid;
    vhf_pkg::vhf_fb_t feedback;
    int bad_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    int n;

    vhf_top #(.HANDSHAKE_CYCLES(HS), .MARGIN_CYCLES(MG)) DUT (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .plc_cmd(plc_cmd), .target_reached(tgt), .select_button(sel),
        .enter_button(ent), .solenoid(solenoid), .feedback(feedback), .led(led), .irq(irq));
    vhf_valve_model valve (.aclk(aclk), .solenoid(solenoid), .sensor_on(sens), .target_reached(tgt));

    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end

    task automatic tick(input int k);
        repeat (k) @(posedge aclk);
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // both channels offered together, each released once its ready is sampled
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic aw_go, w_go;
        aw_go = 1'b1;
        w_go = 1'b1;
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (aw_go || w_go) begin
            @(posedge aclk);
            if (aw_go && awready) begin
                aw_go = 1'b0;
                awvalid <= 1'b0;
            end
            if (w_go && wready) begin
                w_go = 1'b0;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
    endtask

    task automatic rd(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        d = rdata;
    endtask

    // one press of a panel button; rising level counts
    task automatic push(input logic is_sel);
        if (is_sel) sel <= 1'b1;
        else ent <= 1'b1;
        tick(2);
        sel <= 1'b0;
        ent <= 1'b0;
        tick(2);
    endtask

    // walk idle then sv1 onwards for cnt steps (up to sv3) and compare the feedback word
    task automatic map_check(input logic [3:0][4:0] t, input int cnt);
        for (int i = 0; i < cnt; i++) begin
            plc_cmd <= (i == 0) ? 3'h0 : 3'(1 << (i - 1));
            tick(6);
            check("feedback map", feedback, t[i]);
        end
        plc_cmd <= 3'h0;
        tick(6);
    endtask

    function automatic logic drops(input int c, input logic asi);
        if (asi) return c == 16 || (c >= 19 && c <= 22) || c == 31;
        return c == 16 || (c >= 19 && c <= 27) || c >= 29;
    endfunction

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // hang guard, well above the longest sequence
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            give_verdict();
        end
    end

    initial begin
        {awvalid, wvalid, bready, arvalid, rready, sel, ent} <= 7'h14; // response readies stay high
        {awaddr, araddr, wdata, wstrb} <= {8'h00, 8'h00, 32'h0000_0000, 4'hf};
        plc_cmd <= 3'h0;
        sens <= 1'b1;
        aresetn <= 1'b0;
        tick(6);
        aresetn <= 1'b1;
        tick(2);
        map_check({5'h00, 5'h00, 5'h12, 5'h11}, 2);
        rd(8'h00);
        check("ctrl at reset", d, 32'h0);
        wr(8'h00, 32'h8000_0003);
        rd(8'h00);
        check("options refused before setup", d, 32'h0);
        for (int k = 0; k < 3; k++) begin
            wr(8'h04, 32'h0f | (k << 5));
            map_check({5'h18, 5'h14, 5'h12, 5'h11}, 4);
        end
        wr(8'h00, 32'h8000_0002);
        rd(8'h00);
        check("us refused on io-link", d, 32'h0);
        wr(8'h04, 32'h0f);
        repeat (5) push(1'b1);
        check("us menu indicator", led[7], 1'b1);
        push(1'b0);
        rd(8'h00);
        check("us by buttons", d, 32'h2);
        map_check({5'h14, 5'h18, 5'h12, 5'h1d}, 4);
        for (int a = 0; a < 2; a++) begin
            wr(8'h04, a ? 32'h2f : 32'h0f);
            for (int c = 15; c < 32; c++) begin
                wr(8'h08, 32'(c));
                tick(4);
                check("valve state", feedback.valve_state, !drops(c, a[0]));
            end
        end
        wr(8'h08, 32'h0);
        rd(8'h10);
        check("fault flag", d[1], 1'b1);
        wr(8'h04, 32'h0f);
        wr(8'h00, 32'h4);
        rd(8'h00);
        check("us kept by factory restore", d, 32'h2);
        wr(8'h00, 32'h8000_0000);
        repeat (4) push(1'b1);
        check("burst menu indicator", led[3], 1'b1);
        push(1'b0);
        rd(8'h00);
        check("burst by buttons", d, 32'h1);
        wr(8'h10, 32'h3);
        plc_cmd <= 3'h2;
        tick(3);
        check("seat lift drive", solenoid.usl, 1'b1);
        n = 0;
        while (solenoid.usl === 1'b1 && n < 100) begin
            tick(1);
            n++;
        end
        check("drive dropped, command high", {plc_cmd.usl, solenoid.usl}, 2'b10);
        check("handshake", {led[3], feedback.usl_bit}, 2'b11);
        tick(HS - 4);
        check("handshake still held", led[3], 1'b1);
        plc_cmd <= 3'h0;
        tick(10);
        check("done masked", irq, 1'b0);
        rd(8'h10);
        check("done flag", d[0], 1'b1);
        wr(8'h14, 32'h1);
        tick(3);
        check("done raised", irq, 1'b1);
        wr(8'h10, 32'h1);
        tick(3);
        check("done cleared", irq, 1'b0);
        wr(8'h04, 32'h1f);
        wr(8'h18, 32'd20);
        sens <= 1'b0;
        plc_cmd <= 3'h4;
        n = 0;
        repeat (120) begin
            tick(1);
            if (solenoid.lsp === 1'b1) n++;
        end
        check("timed pulse length", n, 32'd30);
        plc_cmd <= 3'h0;
        tick(40);
        wr(8'h00, 32'h4);
        rd(8'h00);
        check("factory restore", d[0], 1'b0);
        rd(8'h40);
        check("unmapped read data", d, 32'h0);
        check("unmapped read resp", rresp, 2'h2);
        wr(8'h40, 32'h1);
        check("unmapped write resp", bresp, 2'h2);
        give_verdict();
    end
endmodule
